// [hdl/rtmcd_consts.svh]
// register offsets, field positions and sizes for the mode command decoder
`ifndef RTMCD_CONSTS_SVH
`define RTMCD_CONSTS_SVH
`define RTMCD_ADDR_PENDING   8'h09
`define RTMCD_ADDR_ENABLES   8'h12
`define RTMCD_ADDR_CONFIG    8'h17
`define RTMCD_CFG_UNDEF_INV  4
`define RTMCD_CFG_SIMPLE     5
`define RTMCD_CFG_ALT_TEST   6
`define RTMCD_IRQ_WHEN_ACC   0
`define RTMCD_CTRL_ACC       2
`define RTMCD_INFO_ACC       0
`define RTMCD_FIRST_DATA_MC  5'h10
`define RTMCD_MC_LAST_CMD    5'h12
`define RTMCD_MC_TEST_WORD   5'h13
`define RTMCD_DESC_WORDS_LOG 2
`define RTMCD_ZERO16         16'h0000
`define RTMCD_ALL_LEGAL      64'h0000000000000000
`define RTMCD_LAST_UNDEF_MC  5'h15
`endif

// [hdl/rtmcd_pkg.sv]
// types shared by the mode command decoder
package rtmcd_pkg;
    typedef enum logic [1:0] {
        RTMCD_SRC_STORED,
        RTMCD_SRC_LAST_CMD,
        RTMCD_SRC_TEST_PRI,
        RTMCD_SRC_TEST_ALT
    } rtmcd_src_type;
    typedef enum {
        RTMCD_IDLE,
        RTMCD_LOG_INFO,
        RTMCD_LOG_ADDR
    } rtmcd_state_type;
endpackage

// [hdl/rtmcd_top.sv]
// remote terminal mode command decoder: validity, legality, response, interrupt log
//
// Function
// - undefined codes ignored when option set
// - undefined set: rx 0-16,18,19; tx 17,20,21
// - undefined-invalid option clear after reset
// - legal valid command answers in form
// - illegal sets message error, status only
// - illegal 16-31 move no data word
// - legality table clears to zero on reset
// - legal undefined codes still carry data
// - codes 0-15 answer status word only
// - codes 16-31 carry one data word
// - top three control bits pick interrupts
// - accessed event sets pending, drives int_n
// - log info and address before int_n
// - address word is descriptor control address
// - plain mode stores data in buffers
// - no circular buffering for mode codes
// - simplified mode keeps data in descriptor
// - one global option, undefined codes only
// - reserved codes follow table, carry data
// - simplified descriptor is four words
// - code 19 data from one of two regs
`timescale 1ns/1ps
`include "rtmcd_consts.svh"
module rtmcd_top import rtmcd_pkg::*; #(
    parameter logic [15:0] DESC_BASE = 16'h0200
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // legality table writes
    input  wire logic        tbl_wr,
    input  wire logic [5:0]  tbl_index,
    input  wire logic        tbl_illegal,
    // decoded mode command
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [4:0]  cmd_code,
    input  wire logic        cmd_tx,
    input  wire logic        cmd_bcast,
    input  wire logic [2:0]  cmd_ctrl_top,
    // response decision
    output logic             resp_valid,
    output logic             resp_ignored,
    output logic             resp_status,
    output logic             resp_data_tx,
    output logic             resp_data_rx,
    output logic             resp_msg_error,
    output logic             resp_status_upd,
    output rtmcd_src_type    resp_src,
    output logic             resp_in_desc,
    output logic             resp_in_buffer,
    output logic [15:0]      resp_desc_addr,
    // interrupt log and interrupt
    output logic             log_wr,
    output logic [15:0]      log_word,
    output logic             int_n
);
    // registers and state
    logic [15:0]     pending_reg;
    logic [15:0]     enables_reg;
    logic [15:0]     config_reg;
    logic [63:0]     illegal_reg;
    rtmcd_state_type state_reg;
    rtmcd_state_type state_next;
    logic [15:0]     addr_reg;

    // descriptor control word address for a code and direction
    function automatic logic [15:0] desc_addr(input logic tx, input logic [4:0] code);
        desc_addr = DESC_BASE + {9'h000, tx, code} * 16'(1 << `RTMCD_DESC_WORDS_LOG);
    endfunction

    // undefined mode code classifier
    function automatic logic is_undef(input logic tx, input logic [4:0] code);
        logic lo;
        lo = (code < `RTMCD_FIRST_DATA_MC);
        if (!tx) begin
            is_undef = lo || code == 5'h10 || code == 5'h12 || code == 5'h13;
        end else begin
            is_undef = code == 5'h11 || code == 5'h14 || code == 5'h15;
        end
    endfunction

    // command decode
    wire logic        cmd_take   = cmd_valid && cmd_ready;
    // control word address of this command
    wire logic [15:0] cmd_desc_addr = desc_addr(cmd_tx, cmd_code);
    wire logic        undef      = is_undef(cmd_tx, cmd_code);
    wire logic        opt_inv    = config_reg[`RTMCD_CFG_UNDEF_INV];
    wire logic        ignore     = undef && opt_inv;
    wire logic        illegal    = illegal_reg[{cmd_tx, cmd_code}];
    wire logic        has_data   = cmd_code >= `RTMCD_FIRST_DATA_MC;
    // reserved and legal undefined codes move data per table
    wire logic        data_ok    = has_data && !illegal;
    wire logic        simple     = config_reg[`RTMCD_CFG_SIMPLE];
    wire logic        alt_test   = config_reg[`RTMCD_CFG_ALT_TEST];
    // interrupt select from control word top bits
    wire logic        acc_sel    = cmd_ctrl_top[`RTMCD_CTRL_ACC];
    wire logic        acc_ev     = cmd_take && !ignore && acc_sel
                                   && enables_reg[`RTMCD_IRQ_WHEN_ACC];
    wire logic        pend_rd    = reg_rd && reg_addr == `RTMCD_ADDR_PENDING;
    // pending only once the address word is out
    wire logic        pend_set   = log_wr && state_reg == RTMCD_IDLE;
    wire logic [15:0] info_word  = 16'(1 << `RTMCD_INFO_ACC);

    rtmcd_src_type src_sel;
    assign src_sel = (cmd_tx && cmd_code == `RTMCD_MC_TEST_WORD)
                     ? (alt_test ? RTMCD_SRC_TEST_ALT : RTMCD_SRC_TEST_PRI)
                     : (cmd_tx && cmd_code == `RTMCD_MC_LAST_CMD) ? RTMCD_SRC_LAST_CMD
                     : RTMCD_SRC_STORED;

    // register read mux
    always_comb begin
        case (reg_addr)
            `RTMCD_ADDR_PENDING: reg_rdata = pending_reg;
            `RTMCD_ADDR_ENABLES: reg_rdata = enables_reg;
            `RTMCD_ADDR_CONFIG:  reg_rdata = config_reg;
            default:             reg_rdata = `RTMCD_ZERO16;
        endcase
    end

    // host registers
    always_ff @(posedge clk) begin
        if (srst) begin
            enables_reg <= `RTMCD_ZERO16;
            config_reg  <= `RTMCD_ZERO16;
        end else if (reg_wr) begin
            if (reg_addr == `RTMCD_ADDR_ENABLES) enables_reg <= reg_wdata;
            if (reg_addr == `RTMCD_ADDR_CONFIG)  config_reg  <= reg_wdata;
        end
    end

    // legality table storage
    always_ff @(posedge clk) begin
        if (srst) begin
            illegal_reg <= `RTMCD_ALL_LEGAL;
        end else if (tbl_wr) begin
            illegal_reg[tbl_index] <= tbl_illegal;
        end
    end

    // pending interrupts, cleared by read, set wins
    always_ff @(posedge clk) begin
        if (srst) begin
            pending_reg <= `RTMCD_ZERO16;
        end else begin
            if (pend_rd) pending_reg <= `RTMCD_ZERO16;
            if (pend_set) pending_reg[`RTMCD_IRQ_WHEN_ACC] <= 1'b1;
        end
    end

    assign int_n = !pending_reg[`RTMCD_IRQ_WHEN_ACC];
    assign cmd_ready = state_reg == RTMCD_IDLE;

    // interrupt log sequencer
    always_comb begin
        case (state_reg)
            RTMCD_IDLE:     state_next = acc_ev ? RTMCD_LOG_INFO : RTMCD_IDLE;
            RTMCD_LOG_INFO: state_next = RTMCD_LOG_ADDR;
            RTMCD_LOG_ADDR: state_next = RTMCD_IDLE;
            default:        state_next = RTMCD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= RTMCD_IDLE;
            addr_reg  <= `RTMCD_ZERO16;
        end else begin
            state_reg <= state_next;
            if (acc_ev) addr_reg <= cmd_desc_addr;
        end
    end

    // info word then address word before int_n
    always_ff @(posedge clk) begin
        if (srst) begin
            log_wr   <= 1'b0;
            log_word <= `RTMCD_ZERO16;
        end else begin
            log_wr   <= state_reg == RTMCD_LOG_INFO || state_reg == RTMCD_LOG_ADDR;
            log_word <= state_reg == RTMCD_LOG_INFO ? info_word : addr_reg;
        end
    end

    // response decision, one cycle after the command is taken
    always_ff @(posedge clk) begin
        if (srst) begin
            resp_valid      <= 1'b0;
            resp_ignored    <= 1'b0;
            resp_status     <= 1'b0;
            resp_data_tx    <= 1'b0;
            resp_data_rx    <= 1'b0;
            resp_msg_error  <= 1'b0;
            resp_status_upd <= 1'b0;
            resp_src        <= RTMCD_SRC_STORED;
            resp_in_desc    <= 1'b0;
            resp_in_buffer  <= 1'b0;
            resp_desc_addr  <= `RTMCD_ZERO16;
        end else begin
            resp_valid      <= cmd_take;
            resp_ignored    <= cmd_take && ignore;
            // broadcast sends nothing; status alone for 0-15
            resp_status     <= cmd_take && !ignore && !cmd_bcast;
            // transmit one data word; not when illegal; legal undefined
            resp_data_tx    <= cmd_take && !ignore && !cmd_bcast && cmd_tx && data_ok;
            // receive one data word; illegal takes none
            resp_data_rx    <= cmd_take && !ignore && !cmd_tx && data_ok;
            // message error when illegal; clear status when legal
            resp_msg_error  <= cmd_take && !ignore && illegal;
            // status untouched when ignored; updated otherwise
            resp_status_upd <= cmd_take && !ignore;
            resp_src        <= src_sel;
            // simplified mode keeps data in descriptor word 4
            resp_in_desc    <= cmd_take && !ignore && data_ok && simple;
            // indexed or ping-pong buffer; never circular
            resp_in_buffer  <= cmd_take && !ignore && data_ok && !simple;
            resp_desc_addr  <= cmd_desc_addr;
        end
    end

    // checks
    AST_IGNORE_SILENT: assert property (@(posedge clk) disable iff (srst)
        cmd_take && ignore |=> !resp_status && !resp_status_upd && resp_ignored)
        else $error("undefined code answered while option set");
    AST_UNDEF_TX: assert property (@(posedge clk) disable iff (srst)
        cmd_take && cmd_tx && cmd_code == 5'h11 && opt_inv |=> resp_ignored)
        else $error("tx code 17 not treated as undefined");
    AST_LEGAL_FORM: assert property (@(posedge clk) disable iff (srst)
        cmd_take && !ignore && !illegal && !cmd_bcast |=> resp_status && !resp_msg_error)
        else $error("legal command not answered in form");
    AST_ILLEGAL_ERR: assert property (@(posedge clk) disable iff (srst)
        cmd_take && !ignore && illegal |=> resp_msg_error && !resp_data_tx && !resp_data_rx)
        else $error("illegal command without message error");
    AST_NO_DATA_LOW: assert property (@(posedge clk) disable iff (srst)
        cmd_take && cmd_code < 5'h10 |=> !resp_data_tx && !resp_data_rx)
        else $error("data word for codes 0-15");
    AST_TX_DATA: assert property (@(posedge clk) disable iff (srst)
        cmd_take && !ignore && !illegal && !cmd_bcast && cmd_tx && cmd_code[4]
        |=> resp_data_tx && resp_status)
        else $error("legal transmit 16-31 without data word");
    AST_LOG_ORDER: assert property (@(posedge clk) disable iff (srst)
        acc_ev |=> ##1 log_wr && log_word == info_word ##1 log_wr ##1 !int_n)
        else $error("log words not written before interrupt");
    AST_LOG_ADDR: assert property (@(posedge clk) disable iff (srst)
        acc_ev |-> ##3 log_word == $past(cmd_desc_addr, 3))
        else $error("logged address is wrong");
    AST_BCAST_QUIET: assert property (@(posedge clk) disable iff (srst)
        cmd_take && cmd_bcast |=> !resp_status && !resp_data_tx)
        else $error("broadcast command transmitted");
    AST_STORE_SPLIT: assert property (@(posedge clk) disable iff (srst)
        resp_in_desc |-> !resp_in_buffer && $past(simple))
        else $error("data stored in both places");

    AST_RESET_OPTION: assert property (@(posedge clk) disable iff (srst)
        $past(srst) |-> !opt_inv)
        else $error("undefined-invalid option set after reset");

    AST_RESET_TABLE: assert property (@(posedge clk) disable iff (srst)
        $past(srst) |-> illegal_reg == `RTMCD_ALL_LEGAL)
        else $error("legality table not cleared by reset");

    AST_ILLEGAL_NO_WORD: assert property (@(posedge clk) disable iff (srst)
        cmd_take && !ignore && illegal && cmd_code[4]
        |=> !resp_data_tx && !resp_data_rx && !resp_in_desc && !resp_in_buffer)
        else $error("illegal mode command moved a data word");

    AST_UNDEF_DATA: assert property (@(posedge clk) disable iff (srst)
        cmd_take && undef && !ignore && !illegal && cmd_code[4] && !cmd_bcast
        |=> resp_data_tx == $past(cmd_tx) && resp_data_rx == !$past(cmd_tx))
        else $error("legal undefined code without its data word");

    AST_RX_DATA: assert property (@(posedge clk) disable iff (srst)
        cmd_take && !ignore && !illegal && !cmd_tx && cmd_code[4]
        |=> resp_data_rx && !resp_data_tx)
        else $error("legal receive 16-31 without data word");

    AST_DEFINED_KEPT: assert property (@(posedge clk) disable iff (srst)
        cmd_take && !undef |=> !resp_ignored && resp_status_upd)
        else $error("defined mode code ignored");

    AST_RESERVED_DATA: assert property (@(posedge clk) disable iff (srst)
        cmd_take && cmd_code > `RTMCD_LAST_UNDEF_MC && !illegal && !(cmd_tx && cmd_bcast)
        |=> !resp_ignored && !resp_msg_error && (resp_data_tx || resp_data_rx))
        else $error("legal reserved code without data word");

    AST_TEST_WORD_SRC: assert property (@(posedge clk) disable iff (srst)
        cmd_take && cmd_tx && cmd_code == `RTMCD_MC_TEST_WORD
        |=> resp_src == ($past(alt_test) ? RTMCD_SRC_TEST_ALT : RTMCD_SRC_TEST_PRI))
        else $error("self-test word from wrong register");

    AST_DESC_STRIDE: assert property (@(posedge clk) disable iff (srst)
        cmd_take
        |=> resp_desc_addr == DESC_BASE + 16'({$past(cmd_tx), $past(cmd_code), 2'b00}))
        else $error("descriptor address not on a four-word stride");

    AST_INT_CLEAR: assert property (@(posedge clk) disable iff (srst)
        pend_rd && !pend_set |=> int_n)
        else $error("interrupt output not released by pending read");

    AST_INT_SET: assert property (@(posedge clk) disable iff (srst)
        pend_set |=> !int_n)
        else $error("pending event lost");

    AST_PLAIN_BUFFER: assert property (@(posedge clk) disable iff (srst)
        cmd_take && !ignore && !illegal && cmd_code[4] && !simple
        |=> resp_in_buffer && !resp_in_desc)
        else $error("plain mode data not sent to buffer");

    AST_NO_ACCESS_LOG: assert property (@(posedge clk) disable iff (srst)
        cmd_take && !acc_sel |=> cmd_ready)
        else $error("interrupt log started without interrupt bit");

    AST_LOW_STATUS: assert property (@(posedge clk) disable iff (srst)
        cmd_take && !ignore && !cmd_bcast && !cmd_code[4] |=> resp_status)
        else $error("codes 0-15 not answered with status");
endmodule

// [verification/rtmcd_bc_model.sv]
// bus controller model that presents decoded mode commands to the decoder
`timescale 1ns/1ps
module rtmcd_bc_model (
    // clock
    input  wire logic       clk,
    // command towards the decoder
    output logic            cmd_valid,
    input  wire logic       cmd_ready,
    output logic [4:0]      cmd_code,
    output logic            cmd_tx,
    output logic            cmd_bcast,
    output logic [2:0]      cmd_ctrl_top
);
    // idle: no command, fields scrambled
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 5'h15;
        cmd_tx = 1'b0;
        cmd_bcast = 1'b0;
        cmd_ctrl_top = 3'h5;
    end
    // present one command, hold it until the take edge
    task automatic issue(input logic [4:0] code, input logic tx, input logic bc,
                         input logic [2:0] ctl, output bit ok);
        int n;
        ok = 1'b0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_tx <= tx;
        cmd_bcast <= bc && !(tx && code >= 5'h10);
        cmd_ctrl_top <= ctl;
        for (n = 0; n < 8 && !ok; n++) begin
            @(negedge clk);
            ok = (cmd_ready === 1'b1);
            @(posedge clk);
        end
        // released fields show the inverse of the last command
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
        cmd_tx <= ~tx;
        cmd_bcast <= ~bc;
        cmd_ctrl_top <= ~ctl;
    endtask
endmodule

// [verification/rt_mode_command_decoder_tb.sv]
// self-checking bench for the mode command decoder
`timescale 1ns/1ps
`include "rtmcd_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module rt_mode_command_decoder_tb import rtmcd_pkg::*;;
    // design inputs driven by the bench
    logic        clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, tbl_wr = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [5:0]  tbl_index = 6'h00;
    logic        tbl_illegal = 1'b0;
    // command wires and design outputs
    logic        cmd_valid, cmd_ready, cmd_tx, cmd_bcast, log_wr, int_n;
    logic [4:0]  cmd_code;
    logic [2:0]  cmd_ctrl_top;
    logic [15:0] reg_rdata, resp_desc_addr, log_word;
    logic        resp_valid, resp_ignored, resp_status, resp_data_tx, resp_data_rx;
    logic        resp_msg_error, resp_status_upd, resp_in_desc, resp_in_buffer;
    rtmcd_src_type resp_src;
    // reference state
    bit          tbl_m [64];
    int          uinv = 0, simple = 0, alt = 0, enab = 0, miscompares = 0, comparisons = 0;

    always #25 clk = ~clk;

    rtmcd_top u_rtmcd_top (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tbl_wr(tbl_wr),
        .tbl_index(tbl_index), .tbl_illegal(tbl_illegal), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_tx(cmd_tx), .cmd_bcast(cmd_bcast),
        .cmd_ctrl_top(cmd_ctrl_top), .resp_valid(resp_valid), .resp_ignored(resp_ignored),
        .resp_status(resp_status), .resp_data_tx(resp_data_tx), .resp_data_rx(resp_data_rx),
        .resp_msg_error(resp_msg_error), .resp_status_upd(resp_status_upd),
        .resp_src(resp_src), .resp_in_desc(resp_in_desc), .resp_in_buffer(resp_in_buffer),
        .resp_desc_addr(resp_desc_addr), .log_wr(log_wr), .log_word(log_word), .int_n(int_n));
    rtmcd_bc_model u_rtmcd_bc_model (.clk(clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_code(cmd_code), .cmd_tx(cmd_tx), .cmd_bcast(cmd_bcast), .cmd_ctrl_top(cmd_ctrl_top));

    // closing report
    task automatic test_done;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // register write, read with compare, legality entry write
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(negedge clk);
        `CHK(reg_rdata, e)
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic tw(input int i, input bit ill);
        @(posedge clk);
        tbl_wr <= 1'b1;
        tbl_index <= 6'(i);
        tbl_illegal <= ill;
        @(posedge clk);
        tbl_wr <= 1'b0;
        tbl_m[i] = ill;
    endtask
    // one command through the partner, compared with the reference decision
    task automatic cmd(input int code, input int tx, input int bc, input int ctl);
        int idx, undef, ign, ill, dat, tdat, irq, src, n;
        bit ok;
        idx = tx * 32 + code;
        bc = bc && !(tx && code >= 16);
        undef = tx ? (code == 17 || code == 20 || code == 21) : (code <= 19 && code != 17);
        ign = uinv && undef;
        ill = tbl_m[idx];
        dat = code >= 16 && !ill && !ign;
        tdat = dat && tx && !bc;
        irq = !ign && ctl[2] && enab;
        src = code == 18 ? 1 : (code == 19 ? (alt ? 3 : 2) : 0);
        u_rtmcd_bc_model.issue(code[4:0], tx[0], bc[0], ctl[2:0], ok);
        @(negedge clk);
        `CHK({ok, resp_valid}, 2'b11)
        `CHK({resp_ignored, resp_status_upd}, {ign[0], !ign})
        `CHK(resp_status, !ign && !bc)
        `CHK(resp_msg_error, !ign && ill)
        `CHK({resp_data_tx, resp_data_rx}, {tdat[0], dat && !tx})
        if (tdat) `CHK(resp_src, src[1:0])
        if (dat) `CHK({resp_in_desc, resp_in_buffer}, {simple[0], !simple})
        if (!ign) `CHK(resp_desc_addr, 16'h0200 + 16'(idx * 4))
        `CHK(int_n, 1'b1)
        if (irq) begin
            for (n = 0; n < 4 && log_wr !== 1'b1; n++) @(negedge clk);
            `CHK({cmd_ready, log_wr, log_word}, 18'h10001)
            @(negedge clk);
            `CHK({log_wr, int_n, log_word}, {2'b11, 16'h0200 + 16'(idx * 4)})
            @(negedge clk);
            `CHK(int_n, 1'b0)
            rd(`RTMCD_ADDR_PENDING, 16'h0001);
            @(negedge clk);
            `CHK(int_n, 1'b1)
        end
    endtask

    // watchdog
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        test_done;
    end
    // main sequence
    initial begin
        int ph, i;
        void'($urandom(32'h299b));
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        // reset values, read-only pending, unmapped offset
        rd(`RTMCD_ADDR_CONFIG, 16'h0000);
        rd(`RTMCD_ADDR_ENABLES, 16'h0000);
        wr(`RTMCD_ADDR_PENDING, 16'hffff);
        rd(`RTMCD_ADDR_PENDING, 16'h0000);
        rd(8'h33, 16'h0000);
        // option phases, random illegal entries, sweep of all 64 commands
        for (ph = 0; ph < 4; ph++) begin
            uinv = ph % 2;
            simple = ph / 2;
            alt = (ph == 1 || ph == 2);
            wr(`RTMCD_ADDR_CONFIG, 16'((uinv << `RTMCD_CFG_UNDEF_INV)
                | (simple << `RTMCD_CFG_SIMPLE) | (alt << `RTMCD_CFG_ALT_TEST)));
            for (i = 0; i < 64; i++) if (ph > 0 && $urandom_range(2) == 0) tw(i, !tbl_m[i]);
            for (i = 0; i < 64; i++) cmd(i % 32, i / 32, $urandom_range(1), $urandom_range(7));
        end
        // interrupt when accessed: raised, masked by control bit, ignored code
        enab = 1;
        wr(`RTMCD_ADDR_ENABLES, 16'h0001);
        rd(`RTMCD_ADDR_ENABLES, 16'h0001);
        cmd(19, 1, 0, 4);
        cmd(5, 1, 1, 7);
        cmd(2, 1, 0, 3);
        cmd(3, 0, 0, 4);
        cmd(31, 0, 0, 6);
        // mid-run reset: option, enables and legality table back to defaults
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        uinv = 0;
        simple = 0;
        alt = 0;
        enab = 0;
        for (i = 0; i < 64; i++) tbl_m[i] = 1'b0;
        rd(`RTMCD_ADDR_CONFIG, 16'h0000);
        rd(`RTMCD_ADDR_ENABLES, 16'h0000);
        for (i = 0; i < 64; i++) cmd(i % 32, i / 32, $urandom_range(1), $urandom_range(7));
        test_done;
    end
endmodule
